// >>> hw/trgh_pkg.sv
package trgh_pkg;

  localparam int unsigned TRGH_ADDR_W = 8;
  localparam int unsigned TRGH_NOISE_N = 6;
  localparam int unsigned TRGH_POLY_W = 31;
  localparam logic [5:0] TRGH_WIDTH_MAX = 6'h20;

  // register byte offsets
  localparam logic [7:0] TRGH_CTL_OFS = 8'h00;
  localparam logic [7:0] TRGH_RED_OFS = 8'h04;
  localparam logic [7:0] TRGH_CMD_OFS = 8'h08;
  localparam logic [7:0] TRGH_RESULT_OFS = 8'h0C;
  localparam logic [7:0] TRGH_POLYG_OFS = 8'h10;
  localparam logic [7:0] TRGH_POLYF_OFS = 8'h14;
  localparam logic [7:0] TRGH_MON_OFS = 8'h18;
  localparam logic [7:0] TRGH_RCCUT_OFS = 8'h1C;
  localparam logic [7:0] TRGH_APCTL_OFS = 8'h20;
  localparam logic [7:0] TRGH_RCSTAT_OFS = 8'h24;
  localparam logic [7:0] TRGH_APSTAT_OFS = 8'h28;
  localparam logic [7:0] TRGH_INTST_OFS = 8'h2C;
  localparam logic [7:0] TRGH_INTMASK_OFS = 8'h30;

  // interrupt bit positions
  localparam int unsigned TRGH_INT_RC = 0;
  localparam int unsigned TRGH_INT_AP = 1;
  localparam int unsigned TRGH_INT_DONE = 2;

  localparam logic [1:0] TRGH_RESP_OKAY = 2'h0;
  localparam logic [1:0] TRGH_RESP_SLVERR = 2'h2;

  // health monitor stream select
  localparam logic [1:0] TRGH_MON_NOISE = 2'h0;
  localparam logic [1:0] TRGH_MON_REDUCED = 2'h1;

  typedef enum logic [0:0] {
    TRGH_IDLE = 1'b0,
    TRGH_COLLECT = 1'b1
  } trgh_gen_state_t;

  // control word layout, msb first; r* fields are reserved and read zero
  typedef struct packed {
    logic [7:0] warmup_delay_field;
    logic [1:0] r0;
    logic [5:0] random_width_field;
    logic [1:0] r1;
    logic [1:0] mon_select;
    logic unbias_en;
    logic reduce_en;
    logic halt_on_proportion_fail;
    logic halt_on_repeat_fail;
    logic [1:0] r2;
    logic [5:0] oscillator_enable_bits;
  } trgh_ctl_t;

  typedef struct packed {
    logic [15:0] window_size;
    logic [15:0] detect_threshold_field;
  } trgh_ap_ctl_t;

  // drive to the hand-built ring cells
  typedef struct packed {
    logic [5:0] enable;
    logic [30:0] poly_galois;
    logic [30:0] poly_fib;
  } trgh_ring_ctl_t;

  localparam trgh_ctl_t TRGH_CTL_RST = trgh_ctl_t'(32'h0000_0000);
  localparam trgh_ap_ctl_t TRGH_APCTL_RST = trgh_ap_ctl_t'(32'h0000_0000);

  typedef struct packed {
    trgh_ctl_t ctl;
    logic [7:0] reduce_periods;
    logic [30:0] poly_g;
    logic [30:0] poly_f;
    logic repeat_test_run_bit;
    logic proportion_test_run_bit;
    logic [7:0] rc_cutoff;
    trgh_ap_ctl_t ap_ctl;
    trgh_ring_ctl_t ring;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [7:0] warm_cnt;
    logic red_acc;
    logic [7:0] red_cnt;
    logic vn_have;
    logic vn_first;
    trgh_gen_state_t gen_st;
    logic [5:0] bit_cnt;
    logic [31:0] shreg;
    logic [31:0] true_random_result_field;
    logic rc_first;
    logic rc_bit;
    logic [7:0] repeat_counter_status;
    logic ap_first;
    logic ap_bit;
    logic [15:0] ap_index;
    logic [15:0] occurrence_counter_status;
    logic [2:0] int_status;
    logic [2:0] int_mask;
    logic irq;
    logic awready;
    logic wready;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } trgh_state_t;

endpackage

// >>> hw/trgh_core.sv
`timescale 1ns/10ps

// Contract
// - result width programmable from 0 to 32
// - six ring noise inputs sampled into bits
// - XOR over all rings, optional XOR reduction over periods
// - unbias pairs: 01 gives 0, 10 gives 1
// - random bits shift into 32-bit register
// - per-ring enable bit; cleared breaks ring
// - drop noise bits during warm-up delay
// - disabled ring sampler held at zero
// - flexible rings take 31-bit feedback polynomial
// - disabled flexible ring gets zero polynomial
// - go command delivers result in result field
// - monitor picks noise, reduced or unbiased stream
// - repeat test: change loads 1, else increment
// - repeat cutoff stops test, flags, freezes status
// - detection with halt bit clears all enables
// - window start latches bit, index 0, count 1
// - in-window: index++, count++ on matching bit
// - proportion cutoff stops test, flags, freezes status
module trgh_core (
  input wire logic clk, // 25 MHz system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [5:0] osc_raw, // ring outputs, asynchronous
  output trgh_pkg::trgh_ring_ctl_t ring_ctl, // enables and applied polynomials
  output logic irq, // level interrupt
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [7:0] s_axi_awaddr, // write byte address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [7:0] s_axi_araddr, // read byte address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp // read response
);

  trgh_pkg::trgh_state_t s_r;
  trgh_pkg::trgh_state_t s_nxt;
  logic das_v, das_b, red_v, red_b, tr_v, tr_b, hm_v, hm_b;
  logic rc_hit, ap_hit, ap_start;
  logic [7:0] rc_cnt_nxt;
  logic [15:0] ap_occ_nxt;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [32:0] reg_image(input trgh_pkg::trgh_state_t st,
                                            input logic [7:0] addr);
    logic [31:0] d;
    logic hit;
    d = 32'h0000_0000;
    hit = 1'b1;
    case ({addr[7:2], 2'b00})
      trgh_pkg::TRGH_CTL_OFS: d = st.ctl;
      trgh_pkg::TRGH_RED_OFS: d = {24'h00_0000, st.reduce_periods};
      trgh_pkg::TRGH_CMD_OFS: d = {31'h0000_0000, st.gen_st == trgh_pkg::TRGH_COLLECT};
      trgh_pkg::TRGH_RESULT_OFS: d = st.true_random_result_field;
      trgh_pkg::TRGH_POLYG_OFS: d = {1'b0, st.poly_g};
      trgh_pkg::TRGH_POLYF_OFS: d = {1'b0, st.poly_f};
      trgh_pkg::TRGH_MON_OFS: d = {30'h0000_0000, st.proportion_test_run_bit,
                                   st.repeat_test_run_bit};
      trgh_pkg::TRGH_RCCUT_OFS: d = {24'h00_0000, st.rc_cutoff};
      trgh_pkg::TRGH_APCTL_OFS: d = st.ap_ctl;
      trgh_pkg::TRGH_RCSTAT_OFS: d = {22'h00_0000, st.ap_bit, st.rc_bit,
                                      st.repeat_counter_status};
      trgh_pkg::TRGH_APSTAT_OFS: d = {st.ap_index, st.occurrence_counter_status};
      trgh_pkg::TRGH_INTST_OFS: d = {29'h0000_0000, st.int_status};
      trgh_pkg::TRGH_INTMASK_OFS: d = {29'h0000_0000, st.int_mask};
      default: hit = 1'b0;
    endcase
    return {hit, d};
  endfunction

  always_comb begin
    logic [32:0] img;
    logic [31:0] wv;
    logic do_wr;
    logic go;
    logic [2:0] int_set;
    logic [31:0] sh;
    logic [5:0] cnt;
    trgh_pkg::trgh_ctl_t c;
    img = 33'h0_0000_0000;
    wv = 32'h0000_0000;
    do_wr = 1'b0;
    go = 1'b0;
    int_set = 3'h0;
    sh = 32'h0000_0000;
    cnt = 6'h00;
    c = trgh_pkg::TRGH_CTL_RST;
    das_v = 1'b0;
    das_b = 1'b0;
    red_v = 1'b0;
    red_b = 1'b0;
    tr_v = 1'b0;
    tr_b = 1'b0;
    hm_v = 1'b0;
    hm_b = 1'b0;
    rc_hit = 1'b0;
    ap_hit = 1'b0;
    ap_start = 1'b0;
    rc_cnt_nxt = s_r.repeat_counter_status;
    ap_occ_nxt = s_r.occurrence_counter_status;
    s_nxt = s_r;

    // bus: address and data taken in either order, response after both
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    do_wr = s_r.aw_have && s_r.w_have;
    if (do_wr) begin
      img = reg_image(s_r, s_r.aw_addr);
      wv = wmerge(img[31:0], s_r.wdata, s_r.wstrb);
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = img[32] ? trgh_pkg::TRGH_RESP_OKAY : trgh_pkg::TRGH_RESP_SLVERR;
      case ({s_r.aw_addr[7:2], 2'b00})
        trgh_pkg::TRGH_CTL_OFS: begin
          c = trgh_pkg::trgh_ctl_t'(wv);
          c.r0 = 2'h0;
          c.r1 = 2'h0;
          c.r2 = 2'h0;
          if (c.random_width_field > trgh_pkg::TRGH_WIDTH_MAX) begin
            c.random_width_field = trgh_pkg::TRGH_WIDTH_MAX;
          end
          s_nxt.ctl = c;
        end
        trgh_pkg::TRGH_RED_OFS: s_nxt.reduce_periods = wv[7:0];
        trgh_pkg::TRGH_CMD_OFS: go = wv[0];
        trgh_pkg::TRGH_POLYG_OFS: s_nxt.poly_g = wv[30:0];
        trgh_pkg::TRGH_POLYF_OFS: s_nxt.poly_f = wv[30:0];
        trgh_pkg::TRGH_MON_OFS: begin
          s_nxt.repeat_test_run_bit = wv[0];
          s_nxt.proportion_test_run_bit = wv[1];
          if (wv[0] && !s_r.repeat_test_run_bit) begin
            s_nxt.rc_first = 1'b1;
          end
          if (wv[1] && !s_r.proportion_test_run_bit) begin
            s_nxt.ap_first = 1'b1;
          end
        end
        trgh_pkg::TRGH_RCCUT_OFS: s_nxt.rc_cutoff = wv[7:0];
        trgh_pkg::TRGH_APCTL_OFS: s_nxt.ap_ctl = trgh_pkg::trgh_ap_ctl_t'(wv);
        trgh_pkg::TRGH_INTST_OFS: begin
          // clear only from strobed data; merged old bits would wipe every flag
          s_nxt.int_status = s_r.int_status & ~(s_r.wdata[2:0] & {3{s_r.wstrb[0]}});
        end
        trgh_pkg::TRGH_INTMASK_OFS: s_nxt.int_mask = wv[2:0];
        default: ;
      endcase
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      img = reg_image(s_r, s_axi_araddr);
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = img[31:0];
      s_nxt.rresp = img[32] ? trgh_pkg::TRGH_RESP_OKAY : trgh_pkg::TRGH_RESP_SLVERR;
    end
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;

    // samplers: two stages, synchronously cleared while the ring is off
    for (int i = 0; i < 6; i++) begin
      s_nxt.sync1[i] = s_r.ctl.oscillator_enable_bits[i] ? osc_raw[i] : 1'b0;
      if (!s_r.ctl.oscillator_enable_bits[i]) begin
        s_nxt.sync2[i] = 1'b0;
      end else begin
        s_nxt.sync2[i] = s_r.sync1[i];
      end
    end
    das_b = ^s_r.sync2;
    das_v = (|s_r.ctl.oscillator_enable_bits) && (s_r.warm_cnt == 8'h00);
    if (s_r.warm_cnt != 8'h00) begin
      s_nxt.warm_cnt = s_r.warm_cnt - 8'h01;
    end

    // reduction: xor of all rings, optionally folded over several periods
    if (das_v) begin
      if (s_r.ctl.reduce_en) begin
        if (s_r.red_cnt == s_r.reduce_periods) begin
          red_v = 1'b1;
          red_b = s_r.red_acc ^ das_b;
          s_nxt.red_acc = 1'b0;
          s_nxt.red_cnt = 8'h00;
        end else begin
          s_nxt.red_acc = s_r.red_acc ^ das_b;
          s_nxt.red_cnt = s_r.red_cnt + 8'h01;
        end
      end else begin
        red_v = 1'b1;
        red_b = das_b;
      end
    end

    // unbias in non-overlapping pairs, keeping the older bit
    if (red_v) begin
      if (s_r.ctl.unbias_en) begin
        s_nxt.vn_have = !s_r.vn_have;
        s_nxt.vn_first = red_b;
        if (s_r.vn_have && (s_r.vn_first != red_b)) begin
          tr_v = 1'b1;
          tr_b = s_r.vn_first;
        end
      end else begin
        tr_v = 1'b1;
        tr_b = red_b;
      end
    end

    // result collection
    if (s_r.gen_st == trgh_pkg::TRGH_COLLECT && tr_v) begin
      sh = {s_r.shreg[30:0], tr_b};
      cnt = s_r.bit_cnt + 6'h01;
      s_nxt.shreg = sh;
      s_nxt.bit_cnt = cnt;
      if (cnt >= s_r.ctl.random_width_field) begin
        s_nxt.true_random_result_field = sh;
        s_nxt.gen_st = trgh_pkg::TRGH_IDLE;
        int_set[trgh_pkg::TRGH_INT_DONE] = 1'b1;
      end
    end
    if (go && s_r.gen_st == trgh_pkg::TRGH_IDLE) begin
      if (s_r.ctl.random_width_field == 6'h00) begin
        s_nxt.true_random_result_field = 32'h0000_0000;
        int_set[trgh_pkg::TRGH_INT_DONE] = 1'b1;
      end else begin
        s_nxt.gen_st = trgh_pkg::TRGH_COLLECT;
        s_nxt.bit_cnt = 6'h00;
        s_nxt.shreg = 32'h0000_0000;
      end
    end

    // health monitor stream select
    case (s_r.ctl.mon_select)
      trgh_pkg::TRGH_MON_NOISE: begin
        hm_v = das_v;
        hm_b = das_b;
      end
      trgh_pkg::TRGH_MON_REDUCED: begin
        hm_v = red_v;
        hm_b = red_b;
      end
      default: begin
        hm_v = tr_v;
        hm_b = tr_b;
      end
    endcase

    // repetition count test
    if (s_r.repeat_test_run_bit && hm_v) begin
      if (s_r.rc_first || hm_b != s_r.rc_bit) begin
        rc_cnt_nxt = 8'h01;
        s_nxt.rc_bit = hm_b;
      end else begin
        rc_cnt_nxt = s_r.repeat_counter_status + 8'h01;
      end
      s_nxt.rc_first = 1'b0;
      s_nxt.repeat_counter_status = rc_cnt_nxt;
      if (rc_cnt_nxt == s_r.rc_cutoff) begin
        rc_hit = 1'b1;
        s_nxt.repeat_test_run_bit = 1'b0;
        int_set[trgh_pkg::TRGH_INT_RC] = 1'b1;
      end
    end

    // adaptive proportion test
    if (s_r.proportion_test_run_bit && hm_v) begin
      ap_start = s_r.ap_first || (s_r.ap_index >= s_r.ap_ctl.window_size - 16'h0001);
      if (ap_start) begin
        s_nxt.ap_bit = hm_b;
        s_nxt.ap_index = 16'h0000;
        ap_occ_nxt = 16'h0001;
      end else begin
        s_nxt.ap_index = s_r.ap_index + 16'h0001;
        if (hm_b == s_r.ap_bit) begin
          ap_occ_nxt = s_r.occurrence_counter_status + 16'h0001;
        end
      end
      s_nxt.ap_first = 1'b0;
      s_nxt.occurrence_counter_status = ap_occ_nxt;
      if (ap_occ_nxt == s_r.ap_ctl.detect_threshold_field) begin
        ap_hit = 1'b1;
        s_nxt.proportion_test_run_bit = 1'b0;
        int_set[trgh_pkg::TRGH_INT_AP] = 1'b1;
      end
    end

    if ((rc_hit && s_r.ctl.halt_on_repeat_fail) ||
        (ap_hit && s_r.ctl.halt_on_proportion_fail)) begin
      s_nxt.ctl.oscillator_enable_bits = 6'h00;
    end
    // enabling rings while all were off starts the warm-up window
    if (s_r.ctl.oscillator_enable_bits == 6'h00 && s_nxt.ctl.oscillator_enable_bits != 6'h00) begin
      s_nxt.warm_cnt = s_nxt.ctl.warmup_delay_field;
    end

    // hardware set wins over a same-cycle software clear
    s_nxt.int_status = s_nxt.int_status | int_set;
    s_nxt.irq = |(s_nxt.int_status & s_nxt.int_mask);
    s_nxt.ring.enable = s_nxt.ctl.oscillator_enable_bits;
    s_nxt.ring.poly_galois = s_nxt.ctl.oscillator_enable_bits[3] ? s_nxt.poly_g : 31'h0;
    s_nxt.ring.poly_fib = s_nxt.ctl.oscillator_enable_bits[5] ? s_nxt.poly_f : 31'h0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ring_ctl = s_r.ring;
  assign irq = s_r.irq;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  rc_load_a: assert property ((s_r.repeat_test_run_bit && hm_v &&
      (s_r.rc_first || hm_b != s_r.rc_bit)) |=> (s_r.repeat_counter_status == 8'h01))
    else $error("repeat counter not loaded with one on change");
  rc_incr_a: assert property ((s_r.repeat_test_run_bit && hm_v && !s_r.rc_first &&
      hm_b == s_r.rc_bit) |=>
      (s_r.repeat_counter_status == $past(s_r.repeat_counter_status) + 8'h01))
    else $error("repeat counter did not increment");
  rc_stop_a: assert property (rc_hit |=> (!s_r.repeat_test_run_bit &&
      s_r.int_status[0] && s_r.repeat_counter_status == $past(s_r.rc_cutoff)))
    else $error("repeat detection did not stop and flag");
  rc_freeze_a: assert property (!s_r.repeat_test_run_bit |=>
      $stable(s_r.repeat_counter_status))
    else $error("repeat status moved while stopped");
  ap_start_a: assert property (ap_start |=> (s_r.ap_index == 16'h0000 &&
      s_r.occurrence_counter_status == 16'h0001 && s_r.ap_bit == $past(hm_b)))
    else $error("window start not latched");
  ap_step_a: assert property ((s_r.proportion_test_run_bit && hm_v && !ap_start) |=>
      (s_r.ap_index == $past(s_r.ap_index) + 16'h0001 && $stable(s_r.ap_bit)))
    else $error("window index did not step");
  ap_stop_a: assert property (ap_hit |=> (!s_r.proportion_test_run_bit &&
      s_r.int_status[1]) ##1 $stable(s_r.ap_index))
    else $error("proportion detection did not stop and freeze");
  halt_en_a: assert property ((rc_hit && s_r.ctl.halt_on_repeat_fail) |=>
      (s_r.ring.enable == 6'h00))
    else $error("halt on repeat failure did not clear enables");
  poly_gate_a: assert property (!s_r.ring.enable[3] |-> s_r.ring.poly_galois == 31'h0)
    else $error("galois polynomial applied while ring off");
  sampler_clr_a: assert property (!s_r.ctl.oscillator_enable_bits[0] |=> !s_r.sync2[0])
    else $error("sampler not held while ring off");
  warm_drop_a: assert property ((s_r.warm_cnt != 8'h00) |-> !das_v)
    else $error("noise bit used during warm-up");
  unbias_a: assert property ((tr_v && s_r.ctl.unbias_en) |->
      (s_r.vn_have && tr_b != red_b))
    else $error("unbias produced a bit without a change");

  rc_detect_c: cover property (rc_hit);
  ap_detect_c: cover property (ap_hit);
  result_done_c: cover property (s_r.gen_st == trgh_pkg::TRGH_COLLECT ##1
      s_r.gen_st == trgh_pkg::TRGH_IDLE);
  unbias_out_c: cover property (tr_v && s_r.ctl.unbias_en);

endmodule

// >>> test/true_random_generator_health_tb.sv
`timescale 1ns/10ps
module true_random_generator_health_tb;
  logic clk, reset_n, irq, tog;
  logic [5:0] osc_raw, noise;
  trgh_pkg::trgh_ring_ctl_t ring_ctl;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int n_fail, checks, cyc;

  trgh_core u_trgh_core (
    .clk(clk), .reset_n(reset_n), .osc_raw(osc_raw), .ring_ctl(ring_ctl), .irq(irq),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // toggling mode gives an alternating noise bit for the unbias pairs
  always @(posedge clk) begin
    osc_raw <= tog ? (osc_raw ^ 6'h01) : noise;
  end

  task complete_run;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      complete_run;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task wait_irq;
    do @(posedge clk); while (irq !== 1'b1);
  endtask

  task t_regs;
    rd(trgh_pkg::TRGH_CTL_OFS);
    chk(rd_val, 32'h0000_0000);
    rd(8'h3C);
    chk(rd_val, 32'h0000_0000);
    chk(32'(resp), 32'(trgh_pkg::TRGH_RESP_SLVERR));
    wr(8'h3C, 32'hFFFF_FFFF);
    chk(32'(resp), 32'(trgh_pkg::TRGH_RESP_SLVERR));
    wr(trgh_pkg::TRGH_CTL_OFS, 32'h003F_0000);
    rd(trgh_pkg::TRGH_CTL_OFS);
    chk(rd_val & 32'h003F_0000, 32'h0020_0000);
    wr(trgh_pkg::TRGH_RED_OFS, 32'h0000_0001);
    wr(trgh_pkg::TRGH_INTMASK_OFS, 32'h0000_0007);
  endtask

  task t_rings;
    wr(trgh_pkg::TRGH_POLYG_OFS, 32'h7FFF_FFFF);
    wr(trgh_pkg::TRGH_POLYF_OFS, 32'h04C1_1DB7);
    wr(trgh_pkg::TRGH_CTL_OFS, 32'h0000_0037);
    repeat (2) @(posedge clk);
    chk(32'(ring_ctl.enable), 32'h0000_0037);
    chk(32'(ring_ctl.poly_galois), 32'h0000_0000);
    chk(32'(ring_ctl.poly_fib), 32'h04C1_1DB7);
    wr(trgh_pkg::TRGH_CTL_OFS, 32'h0000_001F);
    repeat (2) @(posedge clk);
    chk(32'(ring_ctl.poly_galois), 32'h7FFF_FFFF);
    chk(32'(ring_ctl.poly_fib), 32'h0000_0000);
  endtask

  // constant noise: repeat count must stop exactly at the cutoff
  task t_rep(input logic [31:0] ctl, input logic [31:0] exp);
    noise <= 6'h01;
    wr(trgh_pkg::TRGH_CTL_OFS, ctl);
    wr(trgh_pkg::TRGH_RCCUT_OFS, 32'h0000_0005);
    wr(trgh_pkg::TRGH_MON_OFS, 32'h0000_0000);
    wr(trgh_pkg::TRGH_MON_OFS, 32'h0000_0001);
    repeat (40) @(posedge clk);
    rd(trgh_pkg::TRGH_RCSTAT_OFS);
    chk(rd_val & 32'h0000_01FF, exp);
    rd(trgh_pkg::TRGH_MON_OFS);
    chk(rd_val, 32'h0000_0000);
    rd(trgh_pkg::TRGH_CTL_OFS);
    chk(rd_val & 32'h0000_003F, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
    wr(trgh_pkg::TRGH_INTST_OFS, 32'h0000_0001);
    rd(trgh_pkg::TRGH_INTST_OFS);
    chk(rd_val, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
  endtask

  task t_prop;
    wr(trgh_pkg::TRGH_CTL_OFS, 32'h0000_0201);
    wr(trgh_pkg::TRGH_APCTL_OFS, 32'h0010_0004);
    wr(trgh_pkg::TRGH_MON_OFS, 32'h0000_0002);
    repeat (60) @(posedge clk);
    rd(trgh_pkg::TRGH_APSTAT_OFS);
    chk(rd_val, 32'h0003_0004);
    rd(trgh_pkg::TRGH_MON_OFS);
    chk(rd_val, 32'h0000_0000);
    rd(trgh_pkg::TRGH_CTL_OFS);
    chk(rd_val & 32'h0000_003F, 32'h0000_0000);
    rd(trgh_pkg::TRGH_INTST_OFS);
    chk(rd_val, 32'h0000_0002);
    wr(trgh_pkg::TRGH_INTST_OFS, 32'h0000_0002);
  endtask

  // shift register clears on go, so bits above the width must read zero
  task t_gen(input logic [31:0] ctl, input logic [5:0] osc, input logic [31:0] msk,
             input logic [31:0] exp);
    noise <= osc;
    wr(trgh_pkg::TRGH_CTL_OFS, ctl);
    wr(trgh_pkg::TRGH_CMD_OFS, 32'h0000_0001);
    wait_irq;
    rd(trgh_pkg::TRGH_RESULT_OFS);
    chk(rd_val & msk, exp);
    chk(rd_val & ~msk, 32'h0000_0000);
    rd(trgh_pkg::TRGH_CMD_OFS);
    chk(rd_val & 32'h0000_0001, 32'h0000_0000);
    wr(trgh_pkg::TRGH_INTST_OFS, 32'h0000_0004);
  endtask

  task t_warm_unbias;
    noise <= 6'h01;
    wr(trgh_pkg::TRGH_CTL_OFS, 32'h0000_0000);
    wr(trgh_pkg::TRGH_CTL_OFS, 32'hC804_0001);
    wr(trgh_pkg::TRGH_CMD_OFS, 32'h0000_0001);
    repeat (40) @(posedge clk);
    rd(trgh_pkg::TRGH_CMD_OFS);
    chk(rd_val & 32'h0000_0001, 32'h0000_0001);
    wait_irq;
    wr(trgh_pkg::TRGH_INTST_OFS, 32'h0000_0004);
    wr(trgh_pkg::TRGH_CTL_OFS, 32'h0004_0801);
    wr(trgh_pkg::TRGH_CMD_OFS, 32'h0000_0001);
    repeat (40) @(posedge clk);
    rd(trgh_pkg::TRGH_CMD_OFS);
    chk(rd_val & 32'h0000_0001, 32'h0000_0001);
    tog <= 1'b1;
    wait_irq;
    rd(trgh_pkg::TRGH_RESULT_OFS);
    chk(32'(rd_val[3:0] == 4'hF || rd_val[3:0] == 4'h0), 32'h0000_0001);
    chk(rd_val & 32'hFFFF_FFF0, 32'h0000_0000);
    // alternating noise through unbias is a constant stream: repeat test must trip
    wr(trgh_pkg::TRGH_CTL_OFS, 32'h0000_2801);
    wr(trgh_pkg::TRGH_MON_OFS, 32'h0000_0001);
    repeat (40) @(posedge clk);
    rd(trgh_pkg::TRGH_RCSTAT_OFS);
    chk(rd_val & 32'h0000_00FF, 32'h0000_0005);
    rd(trgh_pkg::TRGH_MON_OFS);
    chk(rd_val, 32'h0000_0000);
  endtask

  initial begin
    reset_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, tog} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    noise = 6'h00;
    osc_raw = 6'h00;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs;
    t_rings;
    t_rep(32'h0000_0101, 32'h0000_0105);
    t_rep(32'h0000_1501, 32'h0000_0005);
    t_prop;
    t_gen(32'h0005_0001, 6'h01, 32'h0000_001F, 32'h0000_001F);
    t_gen(32'h0004_0001, 6'h03, 32'h0000_000F, 32'h0000_000F);
    t_gen(32'h0004_0401, 6'h01, 32'h0000_000F, 32'h0000_0000);
    t_gen(32'h0000_0001, 6'h01, 32'hFFFF_FFFF, 32'h0000_0000);
    t_warm_unbias;
    complete_run;
  end
endmodule
